// ### design/addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module addr_decode (
	port_if.dec pif
);
	assign pif.region = host_port_pkg::region_of(pif.addr); // see RULE1
	assign pif.chan = pif.addr[6:5];
	assign pif.local_ofs = pif.addr[4:0];
endmodule

`default_nettype wire

// ### design/host_config_port_decode.sv
// Behaviour
// RULE1 - channel n owns slot n offsets 0x00..0x17 of the 7-bit address
// RULE2 - offsets 0x18..0x1f of slots 0..2 are holes, no channel
// RULE3 - addresses 0x78..0x7f form the device control region
// RULE4 - host waits four clocks before touching the same address again
// RULE5 - accesses to different addresses may follow back to back
// RULE6 - each register is a master stage then a core-clocked slave
// RULE7 - masters written by host, cleared by hard reset only
// RULE8 - slaves are the read copy, cleared by hard or soft reset
// RULE9 - indirect space is pages of 256 words
// RULE10 - indirect page is word bits 9:8, code 3 unused
// RULE11 - indirect word bits 14:10 are ignored
// RULE12 - indirect word bit 15 set means read, clear means write
// RULE13 - hard reset held low at least ten core clocks
// RULE14 - hole writes ignored, hole reads return zero
// RULE15 - new master reaches its slave within four clocks of write end
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module host_config_port_decode (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic soft_rst_i,
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic read_timing_select_i,
	input wire logic [`ADDR_W-1:0] addr_i,
	input wire logic [`DATA_W-1:0] data_i,
	output logic [`DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic upd_busy_o,
	output logic ind_valid_o,
	output logic ind_read_o,
	output logic [1:0] ind_page_o,
	output logic [`IND_WORD_HI:0] ind_word_o,
	output logic [`CHAN_W-1:0] ind_chan_o,
	output logic ind_page_err_o
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [`DATA_W-1:0] master [`WORDS];
	logic [`DATA_W-1:0] slave [`WORDS];

	host_port_pkg::access_state_t state;
	host_port_pkg::access_state_t next_state;
	logic [`ADDR_W-1:0] lat_addr;
	logic [2:0] busy_cnt;

	port_if pif ();

	addr_decode u_dec (
		.pif(pif)
	);

	update_sync u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pif(pif)
	);

	// ----------------------------------------------------------------
	// strobe and region decode
	// ----------------------------------------------------------------
	wire wr_act = !cs_n_i && !wr_n_i;
	wire rd_act = !cs_n_i && !rd_n_i;
	wire in_hole = pif.region == host_port_pkg::REGION_UNDEF;
	wire write_ok = wr_act && !in_hole; // see RULE14
	wire lat_ok = host_port_pkg::region_of(lat_addr)
		!= host_port_pkg::REGION_UNDEF;
	wire wr_end = (state == host_port_pkg::ST_WRITE) && !wr_act;
	// mode 1: a write strobe inside a read releases the bus
	wire next_oe = rd_act && !(read_timing_select_i && wr_act);
	wire [`DATA_W-1:0] next_data = in_hole ? `REG_RESET
		: slave[addr_i]; // see RULE8 see RULE14
	wire [`DATA_W-1:0] upd_word = master[pif.upd_addr];
	wire upd_is_ind = pif.upd && (pif.upd_addr[4:0] == `IND_OFS)
		&& (host_port_pkg::region_of(pif.upd_addr)
		== host_port_pkg::REGION_CHAN);

	assign pif.addr = addr_i;
	assign pif.req = wr_end && lat_ok;
	assign pif.req_addr = lat_addr;

	// ----------------------------------------------------------------
	// access state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			host_port_pkg::ST_IDLE: begin
				if (wr_act) begin
					next_state = host_port_pkg::ST_WRITE;
				end else if (rd_act) begin
					next_state = host_port_pkg::ST_READ;
				end
			end
			host_port_pkg::ST_WRITE: begin
				if (!wr_act) begin
					next_state = host_port_pkg::ST_IDLE;
				end
			end
			host_port_pkg::ST_READ: begin
				if (wr_act) begin
					next_state = host_port_pkg::ST_WRITE;
				end else if (!rd_act) begin
					next_state = host_port_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = host_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= host_port_pkg::ST_IDLE;
			lat_addr <= '0;
		end else begin
			state <= next_state;
			if (wr_act) begin
				lat_addr <= addr_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// master stage: host strobe only, soft reset never reaches it
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin // see RULE6 see RULE7
		if (!nrst_i) begin
			for (int i = 0; i < `WORDS; i++) begin
				master[i] <= `REG_RESET;
			end
		end else if (write_ok) begin
			master[addr_i] <= data_i;
		end
	end

	// ----------------------------------------------------------------
	// slave stage: core clock, loaded from the synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin // see RULE6 see RULE8
		if (!nrst_i) begin
			for (int i = 0; i < `WORDS; i++) begin
				slave[i] <= `REG_RESET;
			end
		end else if (soft_rst_i) begin
			for (int i = 0; i < `WORDS; i++) begin
				slave[i] <= `REG_RESET;
			end
		end else if (pif.upd) begin
			slave[pif.upd_addr] <= upd_word; // see RULE15
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_o <= `REG_RESET;
			data_oe_o <= 1'b0;
		end else begin
			data_o <= next_data;
			data_oe_o <= next_oe;
		end
	end

	// ----------------------------------------------------------------
	// update busy, lets the host pace same-address accesses
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin // see RULE4
		if (!nrst_i) begin
			busy_cnt <= '0;
			upd_busy_o <= 1'b0;
		end else begin
			if (pif.req) begin
				busy_cnt <= `BUSY_RELOAD;
			end else if (busy_cnt != 3'h0) begin
				busy_cnt <= busy_cnt - 3'h1;
			end
			upd_busy_o <= pif.req || (busy_cnt > 3'h1);
		end
	end

	// ----------------------------------------------------------------
	// indirect address word decode
	// ----------------------------------------------------------------
	// bits 14:10 never looked at, so junk there is harmless
	always_ff @(posedge clk_i or negedge nrst_i) begin // see RULE11
		if (!nrst_i) begin
			ind_valid_o <= 1'b0;
			ind_read_o <= 1'b0;
			ind_page_o <= '0;
			ind_word_o <= '0;
			ind_chan_o <= '0;
			ind_page_err_o <= 1'b0;
		end else if (soft_rst_i) begin
			ind_valid_o <= 1'b0;
			ind_read_o <= 1'b0;
			ind_page_o <= '0;
			ind_word_o <= '0;
			ind_chan_o <= '0;
			ind_page_err_o <= 1'b0;
		end else begin
			ind_valid_o <= upd_is_ind;
			if (upd_is_ind) begin
				ind_read_o <= upd_word[`IND_TYPE_BIT]; // see RULE12
				ind_page_o <= upd_word[`IND_PAGE_HI:`IND_PAGE_LO]; // see RULE10
				ind_word_o <= upd_word[`IND_WORD_HI:0]; // see RULE9
				ind_chan_o <= pif.upd_addr[6:5];
				ind_page_err_o <= upd_word[`IND_PAGE_HI:`IND_PAGE_LO]
					== `IND_PAGE_UNUSED; // see RULE10
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	wire in_chan_range = (addr_i <= `CH0_LAST)
		|| (addr_i >= `CH1_FIRST && addr_i <= `CH1_LAST)
		|| (addr_i >= `CH2_FIRST && addr_i <= `CH2_LAST)
		|| (addr_i >= `CH3_FIRST && addr_i <= `CH3_LAST);
	wire in_ctrl_range = addr_i >= `CTRL_FIRST;

	sequence write_finish_s;
		pif.req && !soft_rst_i;
	endsequence

	sequence slave_caught_s;
		slave[$past(pif.req_addr, 3)] == $past(master[pif.req_addr], 3);
	endsequence

	// busy covers the whole update, so the host can pace on it
	sequence busy_run_s;
		upd_busy_o [*3];
	endsequence

	chan_region_a: assert property ( // see RULE1
		in_chan_range |-> pif.region == host_port_pkg::REGION_CHAN)
		else $error("channel address not decoded as channel");
	hole_region_a: assert property ( // see RULE2
		!in_chan_range && !in_ctrl_range |-> in_hole)
		else $error("hole address not decoded as undefined");
	ctrl_region_a: assert property ( // see RULE3
		in_ctrl_range |-> pif.region == host_port_pkg::REGION_CTRL)
		else $error("control address not decoded as control");
	hole_read_a: assert property ( // see RULE14
		in_hole |=> data_o == `REG_RESET)
		else $error("hole read returned nonzero");
	hole_write_a: assert property ( // see RULE14
		wr_act && in_hole
		|=> master[$past(addr_i)] == $past(master[addr_i]))
		else $error("hole write changed storage");
	master_load_a: assert property ( // see RULE6
		write_ok |=> master[$past(addr_i)] == $past(data_i))
		else $error("host write missed its master stage");
	master_keep_a: assert property ( // see RULE7
		soft_rst_i && !wr_act
		|=> master[$past(addr_i)] == $past(master[addr_i]))
		else $error("soft reset disturbed a master stage");
	slave_clear_a: assert property ( // see RULE8
		soft_rst_i && !pif.upd |=> slave[$past(addr_i)] == `REG_RESET)
		else $error("soft reset left a slave stage set");
	read_data_a: assert property ( // see RULE8
		rd_act && !in_hole |=> data_o == $past(slave[addr_i]))
		else $error("read data is not the slave copy");
	update_land_a: assert property ( // see RULE4
		write_finish_s |=> busy_run_s)
		else $error("update busy shorter than the update");
	slave_follow_a: assert property ( // see RULE15
		write_finish_s ##1 !soft_rst_i [*3] |-> slave_caught_s)
		else $error("slave did not take master value in four clocks");
	back_to_back_a: assert property ( // see RULE5
		pif.req ##2 pif.req |-> pif.upd ##2 pif.upd)
		else $error("back to back update dropped");
	ind_type_a: assert property ( // see RULE12
		upd_is_ind && !soft_rst_i
		|=> ind_valid_o && ind_read_o == $past(upd_word[`IND_TYPE_BIT]))
		else $error("indirect access type wrong");
	ind_page_a: assert property ( // see RULE10
		upd_is_ind && !soft_rst_i
		|=> ind_page_err_o == ($past(upd_word[`IND_PAGE_HI:`IND_PAGE_LO])
		== `IND_PAGE_UNUSED))
		else $error("unused page flag wrong");
	ind_word_a: assert property ( // see RULE9
		upd_is_ind && !soft_rst_i
		|=> ind_word_o == $past(upd_word[`IND_WORD_HI:0])
		&& ind_chan_o == $past(pif.upd_addr[6:5]))
		else $error("indirect word or channel wrong");
	soft_ind_a: assert property ( // see RULE8
		soft_rst_i |=> !ind_valid_o && !ind_page_err_o)
		else $error("soft reset left indirect outputs set");
endmodule

`default_nettype wire

// ### design/host_port_cfg.svh
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define ADDR_W 7
`define DATA_W 16
`define CHAN_W 2
`define OFS_W 5
`define WORDS 128

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define CH0_FIRST 7'h00
`define CH0_LAST 7'h17
`define CH1_FIRST 7'h20
`define CH1_LAST 7'h37
`define CH2_FIRST 7'h40
`define CH2_LAST 7'h57
`define CH3_FIRST 7'h60
`define CH3_LAST 7'h77
`define CTRL_FIRST 7'h78
`define CTRL_LAST 7'h7F
`define HOLE_OFS_BITS 2'h3
`define CTRL_CHAN 2'h3

// ----------------------------------------------------------------
// indirect address word layout
// ----------------------------------------------------------------
`define IND_OFS 5'h14
`define IND_TYPE_BIT 15
`define IND_UNUSED_HI 14
`define IND_UNUSED_LO 10
`define IND_PAGE_HI 9
`define IND_PAGE_LO 8
`define IND_WORD_HI 7
`define IND_PAGE_WORDS 256
`define IND_PAGE_UNUSED 2'h3

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define REG_RESET 16'h0000
`define CLK_PERIOD_NS 10
`define UPDATE_CLKS 4
`define SYNC_STAGES 2
`define RESET_MIN_CLKS 10
`define BUSY_RELOAD 3'h3

`endif

// ### design/host_port_pkg.sv
`default_nettype none
`include "host_port_cfg.svh"

package host_port_pkg;

	typedef enum logic [1:0] {
		REGION_CHAN = 2'b00,
		REGION_UNDEF = 2'b01,
		REGION_CTRL = 2'b11
	} region_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b11
	} access_state_t;

	// offsets 0x18..0x1f of slots 0..2 are the holes, slot 3 there is control
	function automatic region_t region_of(input logic [`ADDR_W-1:0] a);
		if (a[4:3] != `HOLE_OFS_BITS) begin // see RULE2
			return REGION_CHAN;
		end else if (a[6:5] == `CTRL_CHAN) begin // see RULE3
			return REGION_CTRL;
		end else begin
			return REGION_UNDEF;
		end
	endfunction

endpackage

`default_nettype wire

// ### design/port_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

interface port_if;
	logic [`ADDR_W-1:0] addr;
	host_port_pkg::region_t region;
	logic [`CHAN_W-1:0] chan;
	logic [`OFS_W-1:0] local_ofs;
	logic req;
	logic [`ADDR_W-1:0] req_addr;
	logic upd;
	logic [`ADDR_W-1:0] upd_addr;

	modport dec (input addr, output region, output chan, output local_ofs);
	modport sync (input req, input req_addr, output upd, output upd_addr);
	modport core (output addr, output req, output req_addr,
		input region, input chan, input local_ofs,
		input upd, input upd_addr);
endinterface

`default_nettype wire

// ### design/update_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module update_sync (
	input wire logic clk_i,
	input wire logic nrst_i,
	port_if.sync pif
);
	logic s1_vld;
	logic s2_vld;
	logic [`ADDR_W-1:0] s1_addr;
	logic [`ADDR_W-1:0] s2_addr;

	// ----------------------------------------------------------------
	// two-stage strobe synchroniser, address rides along
	// ----------------------------------------------------------------
	// one slot per stage: back-to-back ends never collide
	always_ff @(posedge clk_i or negedge nrst_i) begin // see RULE15
		if (!nrst_i) begin
			s1_vld <= 1'b0;
			s2_vld <= 1'b0;
			s1_addr <= '0;
			s2_addr <= '0;
		end else begin
			s1_vld <= pif.req;
			s1_addr <= pif.req_addr;
			s2_vld <= s1_vld;
			s2_addr <= s1_addr;
		end
	end

	assign pif.upd = s2_vld;
	assign pif.upd_addr = s2_addr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sync_delay_a: assert property ( // see RULE15
		@(posedge clk_i) disable iff (!nrst_i) pif.req |-> ##2 pif.upd)
		else $error("update pulse not two cycles after write end");
	addr_carry_a: assert property ( // see RULE5
		@(posedge clk_i) disable iff (!nrst_i)
		pif.req |-> ##2 (pif.upd_addr == $past(pif.req_addr, 2)))
		else $error("update address lost in synchroniser");
endmodule

`default_nettype wire

// ### verif/host_config_port_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module host_config_port_decode_tb;
	typedef struct {
		logic [6:0] a;
		logic [15:0] d;
		logic [15:0] exp;
	} row_t;
	localparam int NROWS = 14;
	row_t rows [NROWS] = '{
		'{7'h00, 16'h1234, 16'h1234}, '{7'h17, 16'hA5C3, 16'hA5C3},
		'{7'h20, 16'h0F1E, 16'h0F1E}, '{7'h37, 16'h5A5A, 16'h5A5A},
		'{7'h40, 16'hC001, 16'hC001}, '{7'h57, 16'h8000, 16'h8000},
		'{7'h60, 16'h0001, 16'h0001}, '{7'h77, 16'hFFFF, 16'hFFFF},
		'{7'h18, 16'hFFFF, 16'h0000}, '{7'h1F, 16'hBEEF, 16'h0000},
		'{7'h38, 16'h7777, 16'h0000}, '{7'h5F, 16'h1111, 16'h0000},
		'{7'h78, 16'h0F0F, 16'h0F0F}, '{7'h7F, 16'hF0F0, 16'hF0F0}
	};
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic soft_rst_i = 1'b0;
	logic rts = 1'b0;
	logic cs_n, wr_n, rd_n, oe, busy, ivld, ird, perr;
	logic [6:0] addr;
	logic [15:0] wdata, rdata, got;
	logic [1:0] ipage, ichan;
	logic [7:0] iword;
	logic gotoe;
	int mismatches = 0;
	int checked = 0;

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .oe_i(oe),
		.cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(addr),
		.wdata_o(wdata));

	host_config_port_decode i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.soft_rst_i(soft_rst_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
		.rd_n_i(rd_n), .read_timing_select_i(rts), .addr_i(addr),
		.data_i(wdata), .data_o(rdata), .data_oe_o(oe),
		.upd_busy_o(busy), .ind_valid_o(ivld), .ind_read_o(ird),
		.ind_page_o(ipage), .ind_word_o(iword), .ind_chan_o(ichan),
		.ind_page_err_o(perr));

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
		i_host.read_word(a, got, gotoe);
		chk("read data", exp, got);
		chk("read enable", 16'h0001, {15'h0000, gotoe});
	endtask

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#50us;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		int n;
		logic [15:0] w;
		// hard reset held well past the minimum low time
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		// ----------------------------------------------------------
		// map: writes back to back to distinct addresses, then reads
		// ----------------------------------------------------------
		for (int i = 0; i < NROWS; i++) begin
			i_host.write_word(rows[i].a, rows[i].d);
		end
		i_host.settle();
		for (int i = 0; i < NROWS; i++) begin
			rd_chk(rows[i].a, rows[i].exp);
		end
		$display("test map done");
		// rewrite one register and watch the update run
		i_host.write_word(7'h00, 16'h4321);
		n = 0;
		while (busy !== 1'b1 && n < 6) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("update busy", 16'h0001, {15'h0000, busy});
		n = 0;
		while (busy === 1'b1 && n < 8) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("busy length", {13'h0000, `BUSY_RELOAD}, n[15:0]);
		i_host.settle();
		rd_chk(7'h00, 16'h4321);
		$display("test update done");
		// soft reset clears the readable copy
		@(posedge clk_i);
		soft_rst_i <= 1'b1;
		@(posedge clk_i);
		soft_rst_i <= 1'b0;
		rd_chk(7'h00, 16'h0000);
		rd_chk(7'h78, 16'h0000);
		$display("test soft reset done");
		// read timing select: a write strobe inside a read
		rts <= 1'b1;
		i_host.rd_wr_word(7'h21, 16'h00C3, gotoe);
		chk("mode one enable", 16'h0000, {15'h0000, gotoe});
		rts <= 1'b0;
		i_host.rd_wr_word(7'h22, 16'h3C00, gotoe);
		chk("mode zero enable", 16'h0001, {15'h0000, gotoe});
		i_host.settle();
		rd_chk(7'h21, 16'h00C3);
		rd_chk(7'h22, 16'h3C00);
		$display("test read timing done");
		// indirect word: one channel per page code, junk in unused bits
		for (int c = 0; c < 4; c++) begin
			w = {c[0], 5'h15 ^ c[4:0], c[1:0], 8'h30 + c[7:0]};
			i_host.write_word({c[1:0], 5'h14}, w);
			n = 0;
			while (ivld !== 1'b1 && n < 10) begin
				@(posedge clk_i);
				#1;
				n++;
			end
			chk("ind valid", 16'h0001, {15'h0000, ivld});
			chk("ind read", {15'h0000, c[0]}, {15'h0000, ird});
			chk("ind page", {14'h0000, c[1:0]}, {14'h0000, ipage});
			chk("ind word", {8'h00, 8'h30 + c[7:0]}, {8'h00, iword});
			chk("ind chan", {14'h0000, c[1:0]}, {14'h0000, ichan});
			chk("page err", {15'h0000, c == 3}, {15'h0000, perr});
			i_host.settle();
		end
		$display("test indirect done");
		// second hard reset in mid-run clears everything
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd_chk(7'h21, 16'h0000);
		chk("ind page after reset", 16'h0000, {14'h0000, ipage});
		$display("test hard reset done");
		tally_and_finish();
	end
endmodule

`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

// ----------------------------------------------------------------
// host processor on the parallel port
// ----------------------------------------------------------------
module host_model (
	input wire logic clk_i,
	input wire logic [`DATA_W-1:0] rdata_i,
	input wire logic oe_i,
	output logic cs_n_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [`ADDR_W-1:0] addr_o,
	output logic [`DATA_W-1:0] wdata_o
);
	initial begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		addr_o = 7'h00;
		wdata_o = 16'h0000;
	end

	// bit 15 of an indirect word is set by the caller: 1 read, 0 write
	task automatic write_word(input logic [`ADDR_W-1:0] a,
		input logic [`DATA_W-1:0] d);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		// released bus must not keep showing the old value
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic read_word(input logic [`ADDR_W-1:0] a,
		output logic [`DATA_W-1:0] d, output logic oe);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		addr_o <= a;
		repeat (2) @(posedge clk_i);
		#1;
		d = rdata_i;
		oe = oe_i;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		addr_o <= ~a;
	endtask

	// read and write strobes together, for the read timing modes
	task automatic rd_wr_word(input logic [`ADDR_W-1:0] a,
		input logic [`DATA_W-1:0] d, output logic oe);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		#1;
		oe = oe_i;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// same address again only after the update has run its course
	task automatic settle;
		repeat (5) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire
